// >>> logic/spa_alu_defs.vh
// constants of the signal processor alu datapath
`ifndef SPA_ALU_DEFS_VH
`define SPA_ALU_DEFS_VH
`define SPA_PROG_WORDS 192
`define SPA_PROG_LAST 8'hbf
`define SPA_RAM_WORDS 40
`define SPA_CONV_ADDR 6'h3f
`define SPA_OP_ABA 3'h0
`define SPA_OP_ABS 3'h1
`define SPA_OP_ADD 3'h2
`define SPA_OP_AND 3'h3
`define SPA_OP_LDA 3'h4
`define SPA_OP_LIM 3'h5
`define SPA_OP_SUB 3'h6
`define SPA_OP_XOR 3'h7
`define SPA_SHIFT_LEFT_TWO 4'h0
`define SPA_SHIFT_LEFT_ONE 4'h1
`define SPA_SHIFT_NONE 4'h2
`define SPA_SHIFT_RIGHT_THIRTEEN 4'hf
`define SPA_INSTR_W 20
`define SPA_F_OP_LSB 17
`define SPA_F_SHIFT_LSB 13
`define SPA_F_DST_LSB 7
`define SPA_F_SRC_LSB 1
`define SPA_F_COND_BIT 0
`endif

// >>> logic/spa_alu.v
// signal processor alu datapath with program store and scratch ram
`timescale 1ns/1ns
`default_nettype none
`include "spa_alu_defs.vh"
module spa_alu #(
   parameter DW = 25
) (
   input wire I_CLK,
   input wire I_SYS_RST,
   input wire I_RUN,
   input wire I_PROG_WE,
   input wire [7:0] I_PROG_ADDR,
   input wire [`SPA_INSTR_W-1:0] I_PROG_DATA,
   input wire I_RAM_WE,
   input wire [5:0] I_RAM_ADDR,
   input wire [DW-1:0] I_RAM_DATA,
   output wire [7:0] O_SEQ,
   output wire [DW-1:0] O_CONV,
   output wire O_CARRY,
   output wire O_OVERFLOW,
   output wire [DW-1:0] O_RESULT,
   output wire O_VALID
);
   reg [`SPA_INSTR_W-1:0] prog_mem [0:`SPA_PROG_WORDS-1];
   reg [DW-1:0] ram [0:`SPA_RAM_WORDS-1];
   wire [7:0] seq;
   reg [DW-1:0] conv_reg;
   reg carry_reg;
   reg ovf_reg;
   reg [DW-1:0] result_reg;
   reg valid_reg;
   wire [`SPA_INSTR_W-1:0] instr;
   wire [2:0] op;
   wire [3:0] shift;
   wire [5:0] dst_addr;
   wire [5:0] src_addr;
   wire cond;
   wire [DW-1:0] src_ram_word;
   wire [DW-1:0] dst_ram_word;
   wire [DW-1:0] src_val;
   wire [DW-1:0] dst_val;
   wire [DW-1:0] shifted;
   wire shift_ovf;
   wire [DW-1:0] abs_v;
   wire [DW:0] carry_chain;
   wire [DW-1:0] sum_bits;
   wire [DW:0] sum;
   wire kill_carry;
   wire top_carry;
   reg do_sub;
   reg [DW-1:0] opa;
   reg cin;
   reg [DW-1:0] res;
   reg c_next;
   reg v_next;
   reg [DW-1:0] conv_next;
   genvar gi;

   spa_seq_ctr #(
      .AW(8)
   ) i_spa_seq_ctr (
      .i_clk(I_CLK),
      .i_rst(I_SYS_RST),
      .i_step(I_RUN),
      .o_seq(seq)
   );

   assign instr = prog_mem[seq];
   assign op = instr[`SPA_F_OP_LSB +: 3];
   assign shift = instr[`SPA_F_SHIFT_LSB +: 4];
   assign dst_addr = instr[`SPA_F_DST_LSB +: 6];
   assign src_addr = instr[`SPA_F_SRC_LSB +: 6];
   assign cond = instr[`SPA_F_COND_BIT];
   // ram words behind both operand fields; codes past the ram are masked below
   assign src_ram_word = ram[src_addr];
   assign dst_ram_word = ram[dst_addr];

   spa_opnd_sel #(
      .DW(DW),
      .RAM_WORDS(`SPA_RAM_WORDS)
   ) i_spa_opnd_sel_src (
      .i_addr(src_addr),
      .i_conv(conv_reg),
      .i_ram_word(src_ram_word),
      .o_val(src_val)
   );

   spa_opnd_sel #(
      .DW(DW),
      .RAM_WORDS(`SPA_RAM_WORDS)
   ) i_spa_opnd_sel_dst (
      .i_addr(dst_addr),
      .i_conv(conv_reg),
      .i_ram_word(dst_ram_word),
      .o_val(dst_val)
   );

   // the source is always shifted before the operation sees it
   spa_src_shift #(
      .DW(DW)
   ) i_spa_src_shift (
      .i_src(src_val),
      .i_code(shift),
      .o_shifted(shifted),
      .o_ovf(shift_ovf)
   );

   spa_abs #(
      .DW(DW)
   ) i_spa_abs (
      .i_val(shifted),
      .o_abs(abs_v)
   );

   always @* begin
      do_sub = (op == `SPA_OP_SUB) && (!cond || carry_reg);
      if (do_sub) begin
         opa = ~shifted;
      end else if (op == `SPA_OP_ABA) begin
         opa = abs_v;
      end else begin
         opa = shifted;
      end
      cin = do_sub;
   end

   // shared ripple adder; exclusive-or runs it with every carry suppressed
   assign kill_carry = (op == `SPA_OP_XOR);
   assign carry_chain[0] = cin;
   generate
      for (gi = 0; gi < DW; gi = gi + 1) begin : g_add
         spa_fa i_spa_fa (
            .i_a(dst_val[gi]),
            .i_b(opa[gi]),
            .i_cin(carry_chain[gi]),
            .i_kill(kill_carry),
            .o_sum(sum_bits[gi]),
            .o_cout(carry_chain[gi+1])
         );
      end
   endgenerate
   assign sum = {carry_chain[DW], sum_bits};
   assign top_carry = sum[DW];

   always @* begin
      conv_next = conv_reg;
      if (dst_addr == `SPA_CONV_ADDR) begin
         conv_next = res;
      end else if ((op == `SPA_OP_SUB) && cond) begin
         // only the lowest bit takes this step's top carry
         conv_next = {conv_reg[DW-1:1], top_carry};
      end
   end

   always @* begin
      res = sum[DW-1:0];
      c_next = top_carry;
      v_next = (dst_val[DW-1] == opa[DW-1]) && (res[DW-1] != dst_val[DW-1]);
      case (op)
         `SPA_OP_ABA, `SPA_OP_ADD, `SPA_OP_SUB: begin
            res = sum[DW-1:0];
         end
         `SPA_OP_ABS: begin
            res = abs_v;
            c_next = 1'b0;
            v_next = shift_ovf;
         end
         `SPA_OP_AND: begin
            res = dst_val & shifted;
            c_next = 1'b0;
            v_next = 1'b0;
         end
         `SPA_OP_LDA: begin
            res = shifted;
            c_next = 1'b0;
            v_next = shift_ovf;
         end
         `SPA_OP_LIM: begin
            // destination sign decides; plus full scale is the largest positive word
            res = dst_val[DW-1] ? {1'b1, {(DW-1){1'b0}}} : {1'b0, {(DW-1){1'b1}}};
            c_next = 1'b0;
            v_next = shift_ovf;
         end
         `SPA_OP_XOR: begin
            res = sum[DW-1:0];
            c_next = 1'b0;
            v_next = 1'b0;
         end
         default: begin
            res = sum[DW-1:0];
         end
      endcase
   end

   always @(posedge I_CLK) begin
      if (I_PROG_WE) begin
         prog_mem[I_PROG_ADDR] <= I_PROG_DATA;
      end
   end

   always @(posedge I_CLK) begin
      if (I_RAM_WE && !I_RUN && (I_RAM_ADDR < `SPA_RAM_WORDS)) begin
         ram[I_RAM_ADDR] <= I_RAM_DATA;
      end else if (I_RUN && (dst_addr < `SPA_RAM_WORDS)) begin
         ram[dst_addr] <= res;
      end
   end

   always @(posedge I_CLK or posedge I_SYS_RST) begin
      if (I_SYS_RST) begin
         conv_reg <= {DW{1'b0}};
         carry_reg <= 1'b0;
         ovf_reg <= 1'b0;
         result_reg <= {DW{1'b0}};
         valid_reg <= 1'b0;
      end else begin
         valid_reg <= I_RUN;
         if (I_RUN) begin
            carry_reg <= c_next;
            ovf_reg <= v_next;
            result_reg <= res;
            conv_reg <= conv_next;
         end
      end
   end

   assign O_SEQ = seq;
   assign O_CONV = conv_reg;
   assign O_CARRY = carry_reg;
   assign O_OVERFLOW = ovf_reg;
   assign O_RESULT = result_reg;
   assign O_VALID = valid_reg;
endmodule // spa_alu

// operand read: conversion register, a ram word, or zero for unused codes
module spa_opnd_sel #(
   parameter DW = 25,
   parameter RAM_WORDS = 40
) (
   input wire [5:0] i_addr,
   input wire [DW-1:0] i_conv,
   input wire [DW-1:0] i_ram_word,
   output reg [DW-1:0] o_val
);
   always @* begin
      if (i_addr == `SPA_CONV_ADDR) begin
         o_val = i_conv;
      end else if (i_addr < RAM_WORDS) begin
         o_val = i_ram_word;
      end else begin
         // unused codes read zero so a stray address cannot leak old data
         o_val = {DW{1'h0}};
      end
   end
endmodule // spa_opnd_sel

// arithmetic source shifter: left two, left one, none, right one to thirteen
module spa_src_shift #(
   parameter DW = 25
) (
   input wire [DW-1:0] i_src,
   input wire [3:0] i_code,
   output reg [DW-1:0] o_shifted,
   output reg o_ovf
);
   reg [DW+1:0] ext;
   reg [DW+1:0] shifted_w;
   reg [3:0] right_amt;

   always @* begin
      // two guard bits of sign so the left shifts can be checked for overflow
      ext = {{2{i_src[DW-1]}}, i_src};
      right_amt = 4'h0;
      o_ovf = 1'h0;
      case (i_code)
         `SPA_SHIFT_LEFT_TWO: begin
            shifted_w = ext << 2;
            o_ovf = (i_src[DW-1:DW-3] != 3'h0) && (i_src[DW-1:DW-3] != 3'h7);
         end
         `SPA_SHIFT_LEFT_ONE: begin
            shifted_w = ext << 1;
            o_ovf = i_src[DW-1] ^ i_src[DW-2];
         end
         `SPA_SHIFT_NONE: begin
            shifted_w = ext;
         end
         default: begin
            right_amt = i_code - `SPA_SHIFT_NONE;
            shifted_w = $signed(ext) >>> right_amt;
         end
      endcase
      o_shifted = shifted_w[DW-1:0];
   end
endmodule // spa_src_shift

// one bit of the shared adder; the carry out can be suppressed
module spa_fa (
   input wire i_a,
   input wire i_b,
   input wire i_cin,
   input wire i_kill,
   output wire o_sum,
   output wire o_cout
);
   assign o_sum = i_a ^ i_b ^ i_cin;
   // suppressed carries turn the adder into a bitwise exclusive-or
   assign o_cout = i_kill ? 1'h0 : ((i_a & i_b) | (i_a & i_cin) | (i_b & i_cin));
endmodule // spa_fa

// two's complement magnitude; the most negative word maps onto itself
module spa_abs #(
   parameter DW = 25
) (
   input wire [DW-1:0] i_val,
   output wire [DW-1:0] o_abs
);
   assign o_abs = i_val[DW-1] ? (~i_val + {{(DW-1){1'h0}}, 1'h1}) : i_val;
endmodule // spa_abs

// program sequence counter: steps through the store and wraps after the last word
module spa_seq_ctr #(
   parameter AW = 8
) (
   input wire i_clk,
   input wire i_rst,
   input wire i_step,
   output reg [AW-1:0] o_seq
);
   always @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_seq <= {AW{1'h0}};
      end else if (i_step) begin
         if (o_seq == `SPA_PROG_LAST) begin
            o_seq <= {AW{1'h0}};
         end else begin
            o_seq <= o_seq + {{(AW-1){1'h0}}, 1'h1};
         end
      end
   end
endmodule // spa_seq_ctr
`default_nettype wire

// >>> tb/spa_alu_asserts.sv
// port checker for the alu datapath
`timescale 1ns/1ns
`default_nettype none
module spa_alu_asserts #(parameter DW = 25) (
   input wire logic I_CLK,
   input wire logic I_SYS_RST,
   input wire logic I_RUN,
   input wire logic [7:0] O_SEQ,
   input wire logic O_CARRY,
   input wire logic [DW-1:0] O_RESULT,
   input wire logic O_VALID
);
   default clocking @(posedge I_CLK); endclocking
   default disable iff (I_SYS_RST);
   property p_inc; I_RUN && O_SEQ != 8'hbf |=> O_SEQ == $past(O_SEQ) + 8'h01; endproperty
   a_inc: assert property (p_inc) else $error("seq step");
   property p_wrap; I_RUN && O_SEQ == 8'hbf |=> O_SEQ == 8'h00; endproperty
   a_wrap: assert property (p_wrap) else $error("seq wrap");
   property p_max; O_SEQ <= 8'hbf; endproperty
   a_max: assert property (p_max) else $error("seq range");
   property p_von; I_RUN |=> O_VALID; endproperty
   a_von: assert property (p_von) else $error("valid");
   property p_voff; !I_RUN |=> !O_VALID; endproperty
   a_voff: assert property (p_voff) else $error("valid");
   property p_seqh; !I_RUN |=> $stable(O_SEQ); endproperty
   a_seqh: assert property (p_seqh) else $error("seq hold");
   property p_resh; !I_RUN |=> $stable(O_RESULT); endproperty
   a_resh: assert property (p_resh) else $error("result hold");
   property p_cyh; !I_RUN |=> $stable(O_CARRY); endproperty
   a_cyh: assert property (p_cyh) else $error("carry hold");
   c_wrap: cover property (I_RUN && O_SEQ == 8'hbf);
   c_carry: cover property (O_VALID && O_CARRY);
   c_run: cover property (I_RUN [*3]);
endmodule // spa_alu_asserts
bind spa_alu spa_alu_asserts #(.DW(DW)) i_spa_alu_asserts (.I_CLK(I_CLK), .I_SYS_RST(I_SYS_RST),
   .I_RUN(I_RUN), .O_SEQ(O_SEQ), .O_CARRY(O_CARRY), .O_RESULT(O_RESULT), .O_VALID(O_VALID));
`default_nettype wire

// >>> tb/spa_seq_model.sv
// sequencer model that fills the program store
`timescale 1ns/1ns
`default_nettype none
module spa_seq_model (
   input wire logic i_clk,
   output logic o_we = 0,
   output logic [7:0] o_addr = 0,
   output logic [19:0] o_data = 0
);
   // words pack op, shift, dst, src, conditional; the table repeats to fill the store
   localparam logic [19:0] PROG_TABLE [13] = '{20'h9e102, 20'h24104, 20'h42100, 20'h04102, 20'hc4100,
      20'hc4101, 20'h64100, 20'hc4101, 20'he4102, 20'ha4100, 20'h44102, 20'ha4100, 20'h85f80};
   task load;
      for (int i = 0; i < 192; i++) begin
         @(posedge i_clk) o_we <= 1;
         o_addr <= 8'(i);
         o_data <= PROG_TABLE[i % 13];
      end
      @(posedge i_clk) o_we <= 0;
      o_data <= ~o_data;
   endtask
   // one word written while the datapath is stopped
   task put(input logic [7:0] a, input logic [19:0] w);
      @(posedge i_clk) o_we <= 1;
      o_addr <= a;
      o_data <= w;
      @(posedge i_clk) o_we <= 0;
   endtask
endmodule // spa_seq_model
`default_nettype wire

// >>> tb/tb_top.sv
// self-checking bench for the alu datapath
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin miscompares++; \
   $display("unexpected %s exp %h got %h", n, e, g); end end
module tb_top;
   logic clk = 0, rst = 1, run = 0, rwe = 0, pwe, c, v, vld;
   logic [5:0] ra = 0;
   logic [24:0] rd = 0, res, conv;
   logic [7:0] pa, seq;
   logic [19:0] pd;
   int miscompares = 0, samples_checked = 0, cyc = 0;
   initial forever #50 clk = ~clk;
   spa_seq_model i_spa_seq_model (.i_clk(clk), .o_we(pwe), .o_addr(pa), .o_data(pd));
   spa_alu #(.DW(25)) i_spa_alu (.I_CLK(clk), .I_SYS_RST(rst), .I_RUN(run), .I_PROG_WE(pwe), .I_PROG_ADDR(pa),
      .I_PROG_DATA(pd), .I_RAM_WE(rwe), .I_RAM_ADDR(ra), .I_RAM_DATA(rd), .O_SEQ(seq), .O_CONV(conv),
      .O_CARRY(c), .O_OVERFLOW(v), .O_RESULT(res), .O_VALID(vld));
   task test_done;
      $display("checked %0d unexpected %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   always @(posedge clk) if (++cyc == 1000) begin
      miscompares++;
      test_done;
   end
   task wram(input [5:0] a, input [24:0] d);
      @(posedge clk) rwe <= 1;
      ra <= a;
      rd <= d;
      @(posedge clk) rwe <= 0;
   endtask
   // one instruction, then result, carry, overflow and valid
   task step(input [24:0] r, input [1:0] f);
      @(posedge clk) run <= 1;
      @(posedge clk) run <= 0;
      #10 `CHK("result", {r, f, 1'h1}, {res, c, v, vld})
   endtask
   task t_arith;
      step(25'h1fffe00, 2'h0);
      step(25'h0000200, 2'h0);
      step(25'h0800200, 2'h0);
      step(25'h0c00200, 2'h0);
      step(25'h0800200, 2'h2);
   endtask
   task t_cond;
      step(25'h0400200, 2'h2);
      `CHK("conv", 25'h0000001, conv)
      step(25'h0400000, 2'h0);
      step(25'h0800000, 2'h0);
      `CHK("conv", 25'h0000000, conv)
   endtask
   task t_logic;
      step(25'h1400000, 2'h0);
      step(25'h1000000, 2'h0);
      step(25'h0c00000, 2'h3);
      step(25'h0ffffff, 2'h0);
      step(25'h0400000, 2'h0);
      `CHK("conv", 25'h0400000, conv)
   endtask
   task t_wrap;
      @(posedge clk) run <= 1;
      repeat (179) @(posedge clk);
      run <= 0;
      #10 `CHK("seq", 8'h00, seq)
   endtask
   // left two on load overflows, left one on abs overflows too
   task t_shift;
      i_spa_seq_model.put(8'h00, 20'h80180);
      i_spa_seq_model.put(8'h01, 20'h22186);
      wram(6'h00, 25'h0400000);
      step(25'h1000000, 2'h1);
      step(25'h0000000, 2'h1);
      `CHK("seq", 8'h02, seq)
   endtask
   initial begin
      repeat (20) @(posedge clk);
      rst <= 0;
      i_spa_seq_model.load;
      wram(6'h00, 25'h0400000);
      wram(6'h01, 25'h1c00000);
      t_arith;
      t_cond;
      t_logic;
      t_wrap;
      t_shift;
      test_done;
   end
endmodule // tb_top
`default_nettype wire
